// *** audio_test_port_defines.svh ***
/*
 * Timing counts and pin-level constants for the digital audio test port.
 * Assumes a 20 MHz system clock.
 */
`ifndef AUDIO_TEST_PORT_DEFINES_SVH
`define AUDIO_TEST_PORT_DEFINES_SVH

`define SAMPLE_BITS        13
`define SAMPLE_RATE_HZ     8000
`define LINK_CLK_HZ        104000
`define SYS_CLK_HZ         20000000
// Half period of the 104 kHz serial clock, rounded down (96 cycles)
`define HALF_BIT_CYCLES    (`SYS_CLK_HZ / (2 * `LINK_CLK_HZ))
// One 125 us sample period (2500 cycles)
`define FRAME_CYCLES       (`SYS_CLK_HZ / `SAMPLE_RATE_HZ)
`define BIT_CNT_W          4
`define DIV_CNT_W          12
`define MODE_NORMAL        2'h0
`define MODE_DOWNLINK      2'h1
`define MODE_UPLINK        2'h2
`define MODE_ACOUSTIC      2'h3
`define REG_CTRL_OFS       4'h0
`define REG_STATUS_OFS     4'h4
`define REG_LAST_OFS       4'h8
`define REG_FRAMES_OFS     4'hC

`endif

// *** audio_test_port_pkg.sv ***
/*
 * Types for the digital audio test port.
 * Assumes audio_test_port_defines.svh is compiled alongside.
 */
`default_nettype none

package audio_test_port_pkg;

   typedef logic [12:0] sample_t;

   typedef enum logic [1:0]
   {
      MODE_NORMAL_E,
      MODE_DOWNLINK_E,
      MODE_UPLINK_E,
      MODE_ACOUSTIC_E
   } port_mode_t;

   // Samples and strobe between the serial engine and the speech path
   typedef struct packed
   {
      logic    valid;
      sample_t data;
   } sample_bus_t;

endpackage

`default_nettype wire

// *** audio_serial_engine.sv ***
/*
 * Serial engine: per 125 us frame issues thirteen clock pulses at
 * 104 kHz, shifts one sample out and one in, MSB first.
 * Assumes serial_in is already synchronised to CLK.
 */
`include "audio_test_port_defines.svh"
`default_nettype none

module audio_serial_engine
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       run_i,
   input  wire audio_test_port_pkg::sample_t tx_sample_i,
   input  wire logic                       serial_in_i,
   output logic                            sclk_o,
   output logic                            serial_out_o,
   output audio_test_port_pkg::sample_bus_t rx_o,
   output logic                            frame_start_o
);

   typedef struct packed
   {
      logic [`DIV_CNT_W-1:0]        frame_cnt;
      logic [`BIT_CNT_W-1:0]        bits_left;
      audio_test_port_pkg::sample_t tx_sh;
      audio_test_port_pkg::sample_t rx_sh;
      logic                         sclk;
      logic                         sdo;
      audio_test_port_pkg::sample_bus_t rx;
      logic                         fstart;
   } eng_t;

   eng_t st_r;
   eng_t st_nxt;

   logic [`DIV_CNT_W-1:0] half_pos;

   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.rx.valid = 1'b0;
      st_nxt.fstart = 1'b0;
      half_pos      = st_r.frame_cnt % `DIV_CNT_W'(`HALF_BIT_CYCLES);
      if (!run_i)
      begin
         // Clock rests high outside test modes
         st_nxt.frame_cnt = '0;
         st_nxt.bits_left = '0;
         st_nxt.sclk      = 1'b1;
      end
      else
      begin
         if (st_r.frame_cnt == `DIV_CNT_W'(`FRAME_CYCLES - 1))
            st_nxt.frame_cnt = '0;
         else
            st_nxt.frame_cnt = st_r.frame_cnt + `DIV_CNT_W'(1);
         if (st_r.frame_cnt == '0)
         begin
            // Exactly thirteen pulses per frame
            st_nxt.bits_left = `BIT_CNT_W'(`SAMPLE_BITS);
            st_nxt.tx_sh     = tx_sample_i;
            st_nxt.fstart    = 1'b1;
         end
         else if (st_r.bits_left != '0 && half_pos == '0)
         begin
            if (st_r.sclk)
            begin
               // Falling edge: transmitter changes data, MSB first
               st_nxt.sclk  = 1'b0;
               st_nxt.sdo   = st_r.tx_sh[12];
               st_nxt.tx_sh = {st_r.tx_sh[11:0], 1'b0};
            end
            else
            begin
               // Rising edge: receiver samples
               st_nxt.sclk      = 1'b1;
               st_nxt.rx_sh     = {st_r.rx_sh[11:0], serial_in_i};
               st_nxt.bits_left = st_r.bits_left - `BIT_CNT_W'(1);
               if (st_r.bits_left == `BIT_CNT_W'(1))
               begin
                  st_nxt.rx.valid = 1'b1;
                  st_nxt.rx.data  = {st_r.rx_sh[11:0], serial_in_i};
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r      <= '0;
         st_r.sclk <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign sclk_o        = st_r.sclk;
   assign serial_out_o  = st_r.sdo;
   assign rx_o          = st_r.rx;
   assign frame_start_o = st_r.fstart;

endmodule

`default_nettype wire

// *** audio_test_port.sv ***
/*
 * Digital audio test port of the mobile unit handset hardware.
 * Decodes the two test control lines (or an over-the-air command),
 * drives the 104 kHz serial clock, injects and extracts 13-bit samples
 * on the uplink and downlink speech paths, and in test modes resets the
 * transcoder and converters from the simulator's low-active reset.
 * Software sees control, status, last sample and a frame count.
 * Assumes the speech path presents/accepts one sample per 125 us on
 * the system clock domain; the simulator pins are asynchronous.
 */
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
// Functional notes
// - Samples are 13-bit linear PCM at 8000 per second each way.
// - One data line per direction, both running together at 104 kbit/s.
// - Simulator reset reinitialises transcoder and A/D, D/A functions; here only in test modes, not in normal mode.
// - Handset makes the 104 kHz clock, pulsing only when data moves.
// - Path diversion by control lines or air command; one suffices. Here the use_air bit picks one source and the other one is ignored.
// - Test modes inject and extract samples on transmit and receive.
// - Port reset line is asserted while low.
// - Sample is 13-bit two's complement, MSB first.
// - Sample on rising edge, change on falling edge, clock idles high.
// - 00 normal, 01 downlink, 10 uplink, 11 converters and acoustics.

`include "audio_test_port_defines.svh"
`default_nettype none

module audio_test_port
(
   input  wire logic                         CLK_I,
   input  wire logic                         RST_I,
   // Simulator pins, asynchronous
   input  wire logic                         TEST_CTRL1_I,
   input  wire logic                         TEST_CTRL2_I,
   input  wire logic                         PORT_RESET_N_I,
   input  wire logic                         SIM_DATA_I,
   output logic                              HANDSET_DATA_O,
   output logic                              DATA_CLK_O,
   // Over-the-air mode selection
   input  wire logic                         AIR_CMD_SEL_I,
   input  wire audio_test_port_pkg::port_mode_t AIR_MODE_I,
   // Avalon-MM slave
   input  wire logic [3:0]                   AVS_ADDRESS_I,
   input  wire logic                         AVS_READ_I,
   input  wire logic                         AVS_WRITE_I,
   input  wire logic [31:0]                  AVS_WRITEDATA_I,
   output logic [31:0]                       AVS_READDATA_O,
   output logic                              AVS_WAITREQUEST_O,
   // Speech path
   input  wire audio_test_port_pkg::sample_t ENC_IN_I,
   input  wire audio_test_port_pkg::sample_t DEC_OUT_I,
   input  wire audio_test_port_pkg::sample_t ADC_OUT_I,
   output audio_test_port_pkg::sample_bus_t ENC_FEED_O,
   output audio_test_port_pkg::sample_bus_t DAC_FEED_O,
   output logic                              SPEECH_RESET_O,
   output audio_test_port_pkg::port_mode_t   MODE_O
);

   // ----------------------------------------------------------------
   // Pin synchronisers and block state
   // ----------------------------------------------------------------
   // Two flops per simulator pin; only the second one feeds logic
   typedef struct packed
   {
      logic [1:0]                      ctl_m;
      logic [1:0]                      ctl_s;
      logic                            rst_m;
      logic                            rst_s;
      logic                            din_m;
      logic                            din_s;
      logic                            use_air;
      audio_test_port_pkg::port_mode_t mode;
      logic                            spch_rst;
      audio_test_port_pkg::sample_t    last_rx;
      logic [31:0]                     rdata;
      logic                            ack;
      audio_test_port_pkg::sample_bus_t enc;
      audio_test_port_pkg::sample_bus_t dac;
      logic [15:0]                     frames;
   } top_t;

   top_t st_r;
   top_t st_nxt;

   // Serial engine connections
   logic                             run;
   audio_test_port_pkg::sample_t     tx_sel;
   audio_test_port_pkg::sample_bus_t rx;
   logic                             fstart;
   logic [31:0]                      rdata_sel;

   // ----------------------------------------------------------------
   // Mode decode and speech path steering
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt          = st_r;
      st_nxt.ctl_m    = {TEST_CTRL1_I, TEST_CTRL2_I};
      st_nxt.ctl_s    = st_r.ctl_m;
      st_nxt.rst_m    = PORT_RESET_N_I;
      st_nxt.rst_s    = st_r.rst_m;
      st_nxt.din_m    = SIM_DATA_I;
      st_nxt.din_s    = st_r.din_m;
      st_nxt.ack      = 1'b0;
      st_nxt.enc.valid = 1'b0;
      st_nxt.dac.valid = 1'b0;
      // Air command sets the mode when use_air is set, otherwise the control lines do
      if (st_r.use_air)
         st_nxt.mode = AIR_MODE_I;
      else
         st_nxt.mode = audio_test_port_pkg::port_mode_t'(st_r.ctl_s);
      // Low line holds transcoder and converters in reset
      // Only in test modes, so normal calls are never disturbed
      st_nxt.spch_rst = !st_r.rst_s && st_r.mode != audio_test_port_pkg::MODE_NORMAL_E;
      if (rx.valid)
      begin
         // Injected samples replace the normal source
         st_nxt.last_rx = rx.data;
         unique case (st_r.mode)
            audio_test_port_pkg::MODE_UPLINK_E:   st_nxt.enc = rx;
            audio_test_port_pkg::MODE_ACOUSTIC_E: st_nxt.dac = rx;
            audio_test_port_pkg::MODE_DOWNLINK_E,
            audio_test_port_pkg::MODE_NORMAL_E:   st_nxt.enc.valid = 1'b0;
         endcase
      end

      // Frame count lets software see that the link is alive
      if (fstart)
         st_nxt.frames = st_r.frames + 16'h0001;

      // One wait state keeps readdata registered; each access costs two cycles
      if ((AVS_READ_I || AVS_WRITE_I) && !st_r.ack)
      begin
         st_nxt.ack   = 1'b1;
         st_nxt.rdata = rdata_sel;
      end
      // Write lands at the edge that sees waitrequest low
      if (AVS_WRITE_I && st_r.ack && AVS_ADDRESS_I == `REG_CTRL_OFS)
         st_nxt.use_air = AVS_WRITEDATA_I[0] | AIR_CMD_SEL_I;
   end

   // ----------------------------------------------------------------
   // Register read multiplexer
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (AVS_ADDRESS_I)
         `REG_CTRL_OFS:   rdata_sel = {31'h0000_0000, st_r.use_air};
         `REG_STATUS_OFS: rdata_sel = {28'h000_0000, st_r.spch_rst, run, st_r.mode};
         `REG_LAST_OFS:   rdata_sel = {19'h0_0000, st_r.last_rx};
         `REG_FRAMES_OFS: rdata_sel = {16'h0000, st_r.frames};
         // Unmapped offsets read zero and ignore writes
         default:         rdata_sel = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (RST_I)
      begin
         st_r       <= '0;
         st_r.rst_m <= 1'b1;
         st_r.rst_s <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // Clock runs only in test modes and out of reset
   assign run = st_r.mode != audio_test_port_pkg::MODE_NORMAL_E && st_r.rst_s;

   // ----------------------------------------------------------------
   // Transmit sample selection
   // ----------------------------------------------------------------
   // The engine latches this at frame start only
   always_comb
   begin
      unique case (st_r.mode)
         audio_test_port_pkg::MODE_UPLINK_E:   tx_sel = ENC_IN_I;
         audio_test_port_pkg::MODE_DOWNLINK_E: tx_sel = DEC_OUT_I;
         audio_test_port_pkg::MODE_ACOUSTIC_E: tx_sel = ADC_OUT_I;
         audio_test_port_pkg::MODE_NORMAL_E:   tx_sel = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // Serial engine, both lines move together
   // ----------------------------------------------------------------
   audio_serial_engine u_engine
   (
      .clk_i         (CLK_I),
      .rst_i         (RST_I),
      .run_i         (run),
      .tx_sample_i   (tx_sel),
      .serial_in_i   (st_r.din_s),
      .sclk_o        (DATA_CLK_O),
      .serial_out_o  (HANDSET_DATA_O),
      .rx_o          (rx),
      .frame_start_o (fstart)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Readdata holds until the next access
   assign AVS_READDATA_O    = st_r.rdata;
   assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !st_r.ack;
   assign ENC_FEED_O        = st_r.enc;
   assign DAC_FEED_O        = st_r.dac;
   assign SPEECH_RESET_O    = st_r.spch_rst;
   assign MODE_O            = st_r.mode;

endmodule

`default_nettype wire

// *** audio_test_port_props.sv ***
/* Checker on the audio test port pins and bus handshake.
   Assumes mode lines only move while the data clock is stopped. */
`default_nettype none
module audio_test_port_props
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic PORT_RESET_N_I,
   input wire logic SIM_DATA_I,
   input wire logic HANDSET_DATA_O,
   input wire logic DATA_CLK_O,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic AVS_WAITREQUEST_O,
   input wire audio_test_port_pkg::sample_bus_t ENC_FEED_O,
   input wire audio_test_port_pkg::sample_bus_t DAC_FEED_O,
   input wire logic SPEECH_RESET_O,
   input wire audio_test_port_pkg::port_mode_t MODE_O
);
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_q_r;
   logic rise;
   logic [7:0] low_r;
   logic [7:0] norm_r;
   logic [3:0] rise_r;
   audio_test_port_pkg::sample_t sh_r;
   assign rise = DATA_CLK_O & ~clk_q_r;
   always_ff @(posedge CLK_I)
   begin
      clk_q_r <= DATA_CLK_O;
      if (RST_I)
      begin
         low_r <= 8'h00;
         norm_r <= 8'h00;
      end
      else
      begin
         low_r <= DATA_CLK_O ? 8'h00 : low_r + 8'h01;
         norm_r <= (MODE_O != audio_test_port_pkg::MODE_NORMAL_E) ? 8'h00 : norm_r + {7'h00, norm_r != 8'hFF};
      end
      if (RST_I || !PORT_RESET_N_I || ENC_FEED_O.valid || DAC_FEED_O.valid)
         rise_r <= 4'h0;
      else if (rise)
         rise_r <= rise_r + 4'h1;
      if (rise)
         sh_r <= {sh_r[11:0], SIM_DATA_I};
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_req; $rose(AVS_READ_I || AVS_WRITE_I); endsequence
   sequence s_ans; AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O; endsequence
   sequence s_held; (!PORT_RESET_N_I && MODE_O != audio_test_port_pkg::MODE_NORMAL_E) [*4]; endsequence
   a_bus_answer: assert property (s_req |-> s_ans)
      else $error("bus answer late");
   a_low_half: assert property (disable iff (RST_I || !PORT_RESET_N_I) $rose(DATA_CLK_O) |-> low_r == 8'h60)
      else $error("clock low phase wrong");
   a_idle_normal: assert property (norm_r == 8'hFF |-> DATA_CLK_O)
      else $error("clock runs in normal mode");
   a_thirteen_rises: assert property (disable iff (RST_I || !PORT_RESET_N_I)
      (ENC_FEED_O.valid || DAC_FEED_O.valid) |-> rise_r == 4'hD)
      else $error("pulse count per sample wrong");
   a_rx_msb_first: assert property ((ENC_FEED_O.valid || DAC_FEED_O.valid)
      |-> (ENC_FEED_O.valid ? ENC_FEED_O.data : DAC_FEED_O.data) == sh_r)
      else $error("received sample wrong");
   a_enc_mode: assert property (ENC_FEED_O.valid |-> MODE_O == audio_test_port_pkg::MODE_UPLINK_E)
      else $error("encoder feed in wrong mode");
   a_dac_mode: assert property (DAC_FEED_O.valid |-> MODE_O == audio_test_port_pkg::MODE_ACOUSTIC_E)
      else $error("converter feed in wrong mode");
   a_tx_on_fall: assert property (disable iff (RST_I || !PORT_RESET_N_I) $changed(HANDSET_DATA_O) |-> $fell(DATA_CLK_O))
      else $error("data changed off falling edge");
   a_reset_on: assert property (s_held |-> SPEECH_RESET_O)
      else $error("speech reset missing");
   a_reset_off: assert property (PORT_RESET_N_I [*4] |-> !SPEECH_RESET_O)
      else $error("speech reset stuck");
endmodule
bind audio_test_port audio_test_port_props i_props (.CLK_I(CLK_I), .RST_I(RST_I), .PORT_RESET_N_I(PORT_RESET_N_I),
   .SIM_DATA_I(SIM_DATA_I), .HANDSET_DATA_O(HANDSET_DATA_O), .DATA_CLK_O(DATA_CLK_O), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .ENC_FEED_O(ENC_FEED_O),
   .DAC_FEED_O(DAC_FEED_O), .SPEECH_RESET_O(SPEECH_RESET_O), .MODE_O(MODE_O));
`default_nettype wire

// *** speech_sim_model.sv ***
/* Behavioural test simulator on the far side of the serial port.
   Assumes the handset makes the data clock; low reset restarts words. */
`default_nettype none
module speech_sim_model
(
   input  wire logic                         link_clk_i,
   input  wire logic                         rst_n_i,
   input  wire audio_test_port_pkg::sample_t tx_i,
   input  wire logic                         data_i,
   output logic                              data_o,
   output audio_test_port_pkg::sample_t      word_o,
   output logic [7:0]                        words_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int idx = 12;
   int n = 0;
   audio_test_port_pkg::sample_t sh;
   initial
   begin
      data_o = 1'b0;
      word_o = '0;
      words_o = 8'h00;
   end
   always @(negedge link_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         idx = 12;
      else
      begin
         data_o = tx_i[idx];
         idx = (idx == 0) ? 12 : idx - 1;
      end
   always @(posedge link_clk_i or negedge rst_n_i)
      if (!rst_n_i)
         n = 0;
      else
      begin
         sh = {sh[11:0], data_i};
         n = n + 1;
         if (n == 13)
         begin
            word_o = sh;
            words_o = words_o + 8'h01;
            n = 0;
         end
      end
endmodule
`default_nettype wire

// *** tb_audio_test_port.sv ***
/* Bench for the audio test port: bus tasks, modes, serial exchange.
   Assumes the checker is bound and the simulator model is compiled. */
`default_nettype none
module tb_audio_test_port;
   timeunit 1ns;
   timeprecision 1ns;
   localparam audio_test_port_pkg::sample_t W_IN = 13'h1_A5C;
   localparam audio_test_port_pkg::sample_t ENC = 13'h0_F3A;
   localparam audio_test_port_pkg::sample_t DEC = 13'h1_2C6;
   localparam audio_test_port_pkg::sample_t ADC = 13'h0_9B1;
   logic clk = 1'b0, rst = 1'b1, c1 = 1'b0, c2 = 1'b0, prn = 1'b1, air = 1'b0, rd = 1'b0, wr = 1'b0;
   logic sd, hd, dclk, wq, sp_rst;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, rdata, q;
   logic [7:0] words, w0;
   audio_test_port_pkg::port_mode_t air_mode = audio_test_port_pkg::MODE_NORMAL_E, mode;
   audio_test_port_pkg::sample_bus_t enc_feed, dac_feed;
   audio_test_port_pkg::sample_t word, exp_tx, enc_last = '0, dac_last = '0;
   int failures = 0, checks = 0, n;
   always #25 clk = ~clk;
   always @(posedge clk)
   begin
      if (enc_feed.valid) enc_last <= enc_feed.data;
      if (dac_feed.valid) dac_last <= dac_feed.data;
   end
   audio_test_port i_dut (.CLK_I(clk), .RST_I(rst), .TEST_CTRL1_I(c1), .TEST_CTRL2_I(c2), .PORT_RESET_N_I(prn),
      .SIM_DATA_I(sd), .HANDSET_DATA_O(hd), .DATA_CLK_O(dclk), .AIR_CMD_SEL_I(air), .AIR_MODE_I(air_mode),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wq), .ENC_IN_I(ENC), .DEC_OUT_I(DEC), .ADC_OUT_I(ADC), .ENC_FEED_O(enc_feed),
      .DAC_FEED_O(dac_feed), .SPEECH_RESET_O(sp_rst), .MODE_O(mode));
   speech_sim_model i_sim (.link_clk_i(dclk), .rst_n_i(prn), .tx_i(W_IN), .data_i(hd), .data_o(sd),
      .word_o(word), .words_o(words));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_s(input audio_test_port_pkg::sample_t got, input audio_test_port_pkg::sample_t exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      @(posedge clk);
      while (wq !== 1'b0 && k < 50)
      begin
         @(posedge clk);
         k++;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k == 50) failures++;
   endtask
   task automatic final_report();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (40000) @(posedge clk);
      failures++;
      final_report();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cmp_v(dclk, 1);
      cmp_v(mode, 0);
      bus(0, 4'h4, 0);
      cmp_v(q, 0);
      bus(1, 4'hC, 32'hFFFF_FFFF);
      bus(0, 4'hC, 0);
      cmp_v(q, 0);
      repeat (3000) @(posedge clk);
      cmp_v(words, 0);
      $display("test idle done");
      for (int m = 1; m < 4; m++)
      begin
         prn <= 1'b0;
         repeat (8) @(posedge clk);
         {c1, c2} <= m[1:0];
         repeat (10) @(posedge clk);
         cmp_v(mode, m);
         cmp_v(sp_rst, 1);
         exp_tx = (m == 1) ? DEC : (m == 2) ? ENC : ADC;
         w0 = words;
         prn <= 1'b1;
         repeat (10) @(posedge clk);
         cmp_v(sp_rst, 0);
         for (n = 0; n < 20000 && words < w0 + 2; n++) @(posedge clk);
         if (n == 20000) failures++;
         cmp_s(word, exp_tx);
         bus(0, 4'h4, 0);
         cmp_v(q[2:0], {1'b1, m[1:0]});
         bus(0, 4'h8, 0);
         cmp_v(q, {19'h0_0000, W_IN});
         if (m == 1) cmp_s(enc_last | dac_last, 13'h0000);
         if (m > 1) cmp_s(m == 2 ? enc_last : dac_last, W_IN);
         $display("test mode %0d done", m);
      end
      bus(0, 4'hC, 0);
      cmp_v(q[15:0] >= 16'h0006, 1);
      prn <= 1'b0;
      repeat (8) @(posedge clk);
      {c1, c2} <= 2'b00;
      air <= 1'b1;
      air_mode <= audio_test_port_pkg::MODE_UPLINK_E;
      bus(1, 4'h0, 0);
      repeat (8) @(posedge clk);
      cmp_v(mode, 2);
      bus(0, 4'h0, 0);
      cmp_v(q, 1);
      air <= 1'b0;
      bus(1, 4'h0, 0);
      repeat (8) @(posedge clk);
      cmp_v(mode, 0);
      $display("test air done");
      final_report();
   end
endmodule
`default_nettype wire
